//--- drc_core.sv
// run-command interpreter and parameter read engine of the positioning drive
`timescale 1ns/10ps
`default_nettype none
`include "drc_params.svh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// R1: record read of model name streams the whole string, ending with null byte.
// R2: segment channel index 04 returns four name bytes; five segments cover string.
// R3: control bit 0 set means jog toward larger positions.
// R4: control bit 1 set means jog toward smaller positions.
// R5: no axle motion at all unless release bit 4 is set.
// R6: control bit 6 set means direct approach without reference loop.
// R7: controller writes zero to reserved and unlisted control bits.
// R8: signed target in 1/100 mm, default zero, taken when bit 2 set.
// R9: target unit assumes scaling numerator 400.
// R10: both jog bits set together means standstill.
// R11: control word and target reset to zero.
module drc_core (
	input wire logic clk,
	input wire logic rst,
	input wire logic pd_valid,
	input wire logic [15:0] pd_ctrl,
	input wire logic [31:0] pd_target,
	input wire logic rec_req,
	input wire logic [7:0] rec_index,
	output logic rec_valid,
	output logic [7:0] rec_byte,
	output logic rec_last,
	output logic rec_err,
	input wire logic seg_req,
	input wire logic [7:0] seg_param,
	input wire logic [7:0] seg_index,
	input wire logic [2:0] seg_num,
	output logic seg_valid,
	output logic [31:0] seg_data,
	output logic seg_err,
	output logic [15:0] ctrl_word,
	output logic [31:0] goal_pos,
	output logic [1:0] motion,
	output logic direct_run,
	output logic [15:0] scale_num,
	output logic ctrl_illegal
);
	//////////////////////////////////////////////////////////////////////////
	drc_name_if name_bus ();
	drc_name_rom u_rom (
		.clk(clk),
		.rst(rst),
		.store(name_bus)
	);
	//////////////////////////////////////////////////////////////////////////
	// cyclic process data: control word and target
	logic [15:0] ctrl_q, ctrl_d;
	logic [31:0] goal_q, goal_d;
	logic [1:0] motion_q, motion_d;
	logic direct_q, direct_d;
	logic illegal_q, illegal_d;
	logic up, dn, rel;
	always_comb begin
		ctrl_d = ctrl_q;
		goal_d = goal_q;
		illegal_d = illegal_q;
		if (pd_valid) begin
			ctrl_d = pd_ctrl;
			// flag only: a stray bit is the controller's fault, not ours to mask
			illegal_d = |(pd_ctrl & ~`DRC_CTRL_LEGAL); // R7
			if (pd_ctrl[`DRC_BIT_TAKE]) begin
				goal_d = pd_target; // R8
			end
		end
		up = ctrl_q[`DRC_BIT_JOG_UP];
		dn = ctrl_q[`DRC_BIT_JOG_DN];
		rel = ctrl_q[`DRC_BIT_RELEASE];
		motion_d = drc_pkg::DRC_STOP;
		if (!rel) begin
			motion_d = drc_pkg::DRC_STOP; // R5
		end else if (up && dn) begin
			motion_d = drc_pkg::DRC_STOP; // R10
		end else if (up) begin
			motion_d = drc_pkg::DRC_JOG_UP; // R3
		end else if (dn) begin
			motion_d = drc_pkg::DRC_JOG_DN; // R4
		end else if (ctrl_q[`DRC_BIT_TAKE]) begin
			motion_d = drc_pkg::DRC_POSITION; // R5
		end
		direct_d = rel && ctrl_q[`DRC_BIT_DIRECT]; // R6
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `DRC_CTRL_RESET; // R11
			goal_q <= `DRC_TARGET_RESET; // R11
			motion_q <= drc_pkg::DRC_STOP;
			direct_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			goal_q <= goal_d;
			motion_q <= motion_d;
			direct_q <= direct_d;
			illegal_q <= illegal_d;
		end
	end
	//////////////////////////////////////////////////////////////////////////
	// record read and segment engine share the single-port name store
	drc_pkg::drc_rd_state_t st_q, st_d;
	logic [4:0] addr_q, addr_d;
	logic [2:0] cnt_q, cnt_d;
	logic seg_mode_q, seg_mode_d;
	logic pipe_q, pipe_d;
	logic [4:0] paddr_q, paddr_d;
	logic rv_q, rv_d, rl_q, rl_d, re_q, re_d;
	logic [7:0] rb_q, rb_d;
	logic sv_q, sv_d, se_q, se_d;
	logic [31:0] sd_q, sd_d;
	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		cnt_d = cnt_q;
		seg_mode_d = seg_mode_q;
		pipe_d = 1'b0;
		paddr_d = addr_q;
		rv_d = 1'b0;
		rl_d = 1'b0;
		re_d = 1'b0;
		rb_d = rb_q;
		sv_d = 1'b0;
		se_d = 1'b0;
		sd_d = sd_q;
		unique case (st_q)
			drc_pkg::DRC_IDLE: begin
				// record read wins a same-cycle collision; the segment request is dropped without seg_err
				if (rec_req) begin
					if (rec_index == `DRC_PAR_MODEL) begin
						st_d = drc_pkg::DRC_SEND; // R1
						seg_mode_d = 1'b0;
						addr_d = 5'h00;
					end else begin
						re_d = 1'b1;
					end
				end else if (seg_req) begin
					if (seg_param == `DRC_PAR_MODEL && seg_index == `DRC_SEG_IDX_MODEL &&
						seg_num < `DRC_SEG_COUNT) begin
						st_d = drc_pkg::DRC_SEND; // R2
						seg_mode_d = 1'b1;
						cnt_d = 3'h0;
						addr_d = 5'({seg_num, 2'b00});
					end else begin
						se_d = 1'b1;
					end
				end
			end
			drc_pkg::DRC_SEND: begin
				pipe_d = 1'b1;
				addr_d = addr_q + 5'h01;
				if (seg_mode_q) begin
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == `DRC_SEG_BYTES - 3'h1) begin
						st_d = drc_pkg::DRC_IDLE;
					end
				end else if (addr_q == `DRC_NAME_BYTES - 5'h01) begin
					st_d = drc_pkg::DRC_IDLE;
				end
			end
			default: st_d = drc_pkg::DRC_IDLE;
		endcase
		if (pipe_q) begin
			if (seg_mode_q) begin
				sd_d = {sd_q[23:0], name_bus.data}; // R2
				sv_d = (paddr_q[1:0] == 2'b11);
			end else begin
				rv_d = 1'b1;
				rb_d = name_bus.data;
				rl_d = (paddr_q == `DRC_NAME_BYTES - 5'h01); // R1
			end
		end
	end
	assign name_bus.addr = addr_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= drc_pkg::DRC_IDLE;
			addr_q <= 5'h00;
			cnt_q <= 3'h0;
			seg_mode_q <= 1'b0;
			pipe_q <= 1'b0;
			paddr_q <= 5'h00;
			rv_q <= 1'b0;
			rl_q <= 1'b0;
			re_q <= 1'b0;
			rb_q <= 8'h00;
			sv_q <= 1'b0;
			se_q <= 1'b0;
			sd_q <= 32'h00000000;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			cnt_q <= cnt_d;
			seg_mode_q <= seg_mode_d;
			pipe_q <= pipe_d;
			paddr_q <= paddr_d;
			rv_q <= rv_d;
			rl_q <= rl_d;
			re_q <= re_d;
			rb_q <= rb_d;
			sv_q <= sv_d;
			se_q <= se_d;
			sd_q <= sd_d;
		end
	end
	//////////////////////////////////////////////////////////////////////////
	logic [15:0] num_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			num_q <= `DRC_SCALE_NUM; // R9
		end else begin
			num_q <= `DRC_SCALE_NUM;
		end
	end
	assign rec_valid = rv_q;
	assign rec_byte = rb_q;
	assign rec_last = rl_q;
	assign rec_err = re_q;
	assign seg_valid = sv_q;
	assign seg_data = sd_q;
	assign seg_err = se_q;
	assign ctrl_word = ctrl_q;
	assign goal_pos = goal_q;
	assign motion = motion_q;
	assign direct_run = direct_q;
	assign scale_num = num_q;
	assign ctrl_illegal = illegal_q;
endmodule : drc_core
`default_nettype wire

//--- drc_params.svh
// constants for the drive run-command block
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH
`define DRC_PAR_MODEL 8'h0D
`define DRC_PAR_VERSION 8'h0E
`define DRC_PAR_CTRL 8'h20
`define DRC_PAR_TARGET 8'h21
`define DRC_SEG_IDX_MODEL 8'h04
`define DRC_SEG_COUNT 3'h5
`define DRC_SEG_BYTES 3'h4
`define DRC_NAME_BYTES 5'h14
`define DRC_BIT_JOG_UP 0
`define DRC_BIT_JOG_DN 1
`define DRC_BIT_TAKE 2
`define DRC_BIT_RELEASE 4
`define DRC_BIT_DIRECT 6
`define DRC_BIT_TOGGLE 13
`define DRC_CTRL_LEGAL 16'h2057
`define DRC_CTRL_RESET 16'h0000
`define DRC_TARGET_RESET 32'h00000000
`define DRC_SCALE_NUM 16'h0190
`define DRC_VERSION_VAL 32'h00010000
`endif

//--- drc_pkg.sv
// types for the drive run-command block
package drc_pkg;
	typedef enum logic [1:0] {
		DRC_IDLE = 2'b00,
		DRC_SEND = 2'b01
	} drc_rd_state_t;
	typedef enum logic [1:0] {
		DRC_STOP = 2'b00,
		DRC_JOG_UP = 2'b01,
		DRC_JOG_DN = 2'b10,
		DRC_POSITION = 2'b11
	} drc_motion_t;
endpackage : drc_pkg

//--- drc_name_if.sv
// carrier between the read engine and the model-name store
`timescale 1ns/10ps
`default_nettype none
interface drc_name_if;
	logic [4:0] addr;
	logic [7:0] data;
	modport rom (input addr, output data);
	modport user (output addr, input data);
endinterface : drc_name_if
`default_nettype wire

//--- drc_name_rom.sv
// model-name string store, registered read
`timescale 1ns/10ps
`default_nettype none
`include "drc_params.svh"
module drc_name_rom (
	input wire logic clk,
	input wire logic rst,
	drc_name_if.rom store
);
	// arbitrary neutral name, null-terminated and zero-padded to 20 bytes
	localparam logic [159:0] NAME_TEXT = 160'h4452565F4D4F44454C5F41303100000000000000;
	logic [7:0] data_q;
	logic [7:0] data_d;
	always_comb begin
		data_d = 8'h00;
		if (store.addr < `DRC_NAME_BYTES) begin
			data_d = NAME_TEXT[8'(159 - 8 * store.addr) -: 8];
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_q <= 8'h00;
		end else begin
			data_q <= data_d;
		end
	end
	assign store.data = data_q;
endmodule : drc_name_rom
`default_nettype wire

//--- drc_plc_model.sv
// controller stand-in: cyclic process data and segment channel requests
`timescale 1ns/10ps
`default_nettype none
`include "drc_params.svh"
module drc_plc_model (
	input wire logic clk,
	output logic pd_valid,
	output logic [15:0] pd_ctrl,
	output logic [31:0] pd_target,
	output logic seg_req,
	output logic [7:0] seg_param,
	output logic [7:0] seg_index,
	output logic [2:0] seg_num
);
	initial {pd_valid, pd_ctrl, pd_target, seg_req, seg_param, seg_index, seg_num} = '0;
	// reserved bits cleared here; send_stray breaks that on purpose
	task automatic send_pd(input logic [15:0] c, input logic [31:0] t);
		@(posedge clk);
		pd_valid <= 1'b1;
		pd_ctrl <= c & `DRC_CTRL_LEGAL;
		pd_target <= t;
		@(posedge clk);
		pd_valid <= 1'b0;
		pd_ctrl <= ~c;
		pd_target <= ~t;
	endtask : send_pd
	task automatic seg_get(input logic [7:0] ix, input logic [2:0] n);
		@(posedge clk);
		seg_req <= 1'b1;
		seg_param <= `DRC_PAR_MODEL;
		seg_index <= ix;
		seg_num <= n;
		@(posedge clk);
		seg_req <= 1'b0;
		seg_num <= ~n;
	endtask : seg_get
	// deliberate reserved-bit breach, so the design's flag can be seen
	task automatic send_stray(input logic [15:0] c);
		@(posedge clk);
		pd_valid <= 1'b1;
		pd_ctrl <= c;
		@(posedge clk);
		pd_valid <= 1'b0;
		pd_ctrl <= ~c;
	endtask : send_stray
endmodule : drc_plc_model
`default_nettype wire

//--- drc_core_monitor.sv
// concurrent checks on the run-command block ports
`timescale 1ns/10ps
`default_nettype none
module drc_core_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic pd_valid,
	input wire logic [15:0] pd_ctrl,
	input wire logic [31:0] pd_target,
	input wire logic rec_valid,
	input wire logic [7:0] rec_byte,
	input wire logic rec_last,
	input wire logic seg_req,
	input wire logic seg_valid,
	input wire logic [15:0] ctrl_word,
	input wire logic [31:0] goal_pos,
	input wire logic [1:0] motion,
	input wire logic direct_run
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_release_gate: assert property (!ctrl_word[4] |=> motion == 2'h0) else $error("moved unreleased");
	a_jog_up: assert property (ctrl_word[4] && ctrl_word[1:0] == 2'h1 |=> motion == 2'h1) else $error("no jog up");
	a_jog_down: assert property (ctrl_word[4] && ctrl_word[1:0] == 2'h2 |=> motion == 2'h2) else $error("no jog dn");
	a_jog_both: assert property (ctrl_word[1:0] == 2'h3 |=> motion == 2'h0) else $error("double jog moved");
	a_direct_run: assert property (ctrl_word[6] |=> direct_run == $past(ctrl_word[4])) else $error("direct bad");
	a_goal_hold: assert property (pd_valid && !pd_ctrl[2] |=> $stable(goal_pos)) else $error("goal moved");
	a_goal_load: assert property (pd_valid && pd_ctrl[2] |=> goal_pos == $past(pd_target)) else $error("goal lost");
	a_rec_last: assert property (rec_last |-> rec_valid && rec_byte == 8'h00) else $error("bad last byte");
	a_seg_wait: assert property (seg_valid |-> $past(seg_req, 6)) else $error("segment latency");
	c_position: cover property (motion == 2'h3);
	c_rec_end: cover property (rec_last);
	c_seg: cover property (seg_valid);
endmodule : drc_core_monitor
`default_nettype wire

//--- drive_run_command_params_test.sv
// self-checking bench for the run-command block
`timescale 1ns/10ps
`default_nettype none
`include "drc_params.svh"
module drive_run_command_params_test;
	logic clk = 1'b0, rst = 1'b1, rec_req = 1'b0;
	logic [7:0] rec_index = 8'h00;
	logic pd_valid, rec_valid, rec_last, rec_err, seg_req, seg_valid, seg_err, direct_run, ctrl_illegal;
	logic [15:0] pd_ctrl, ctrl_word, scale_num;
	logic [31:0] pd_target, goal_pos, seg_data;
	logic [7:0] seg_param, seg_index, rec_byte;
	logic [2:0] seg_num;
	logic [1:0] motion;
	logic [159:0] nm = {"DRV_MODEL_A01", 56'h0};
	logic [15:0] cw [6] = '{16'h0011, 16'h0012, 16'h0001, 16'h0013, 16'h0054, 16'h0010};
	logic [1:0] mv [6] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h3, 2'h0};
	int err_count = 0, n_tests = 0;
	always #2.5 clk = ~clk;
	drc_core dut (.clk(clk), .rst(rst), .pd_valid(pd_valid), .pd_ctrl(pd_ctrl), .pd_target(pd_target),
		.rec_req(rec_req), .rec_index(rec_index), .rec_valid(rec_valid), .rec_byte(rec_byte), .rec_last(rec_last),
		.rec_err(rec_err), .seg_req(seg_req), .seg_param(seg_param), .seg_index(seg_index), .seg_num(seg_num),
		.seg_valid(seg_valid), .seg_data(seg_data), .seg_err(seg_err), .ctrl_word(ctrl_word), .goal_pos(goal_pos),
		.motion(motion), .direct_run(direct_run), .scale_num(scale_num), .ctrl_illegal(ctrl_illegal));
	drc_plc_model plc (.clk(clk), .pd_valid(pd_valid), .pd_ctrl(pd_ctrl), .pd_target(pd_target),
		.seg_req(seg_req), .seg_param(seg_param), .seg_index(seg_index), .seg_num(seg_num));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", s, exp, got);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// bounded wait, sampled just after the edge so registered outputs have settled
	task automatic wait_hi(ref logic s);
		for (int i = 0; i < 30 && s !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk("handshake", s, 1);
	endtask : wait_hi
	task automatic rec_pulse(input logic [7:0] ix);
		@(posedge clk);
		rec_req <= 1'b1;
		rec_index <= ix;
		@(posedge clk);
		rec_req <= 1'b0;
		rec_index <= ~ix;
	endtask : rec_pulse
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("reset", {ctrl_word, 14'h0, motion}, 32'h0);
		chk("goal_pos", goal_pos, 32'h0);
		chk("scale_num", scale_num, 32'h190);
		$display("done reset");
		for (int k = 0; k < 6; k++) begin
			plc.send_pd(cw[k], 32'hFFFFFB2E - k);
			repeat (2) @(posedge clk);
			#1;
			chk("motion", motion, mv[k]);
			chk("direct_run", direct_run, cw[k][4] & cw[k][6]);
			chk("ctrl_word", ctrl_word, cw[k]);
		end
		chk("goal_pos", goal_pos, 32'hFFFFFB2A);
		plc.send_stray(16'h0118);
		#1;
		chk("ctrl_word", ctrl_word, 32'h0118);
		chk("ctrl_illegal", ctrl_illegal, 1);
		chk("goal_pos", goal_pos, 32'hFFFFFB2A);
		plc.send_pd(16'h2010, 32'h00000000);
		#1;
		chk("ctrl_illegal", ctrl_illegal, 0);
		chk("ctrl_word", ctrl_word, 32'h2010);
		$display("done motion");
		rec_pulse(`DRC_PAR_MODEL);
		wait_hi(rec_valid);
		for (int b = 0; b < 20; b++) begin
			chk("rec", {rec_valid, rec_last, rec_byte}, {1'b1, b == 19, nm[159-8*b -: 8]});
			@(posedge clk);
			#1;
		end
		rec_pulse(8'h30);
		#1;
		chk("rec_err", rec_err, 1);
		$display("done record");
		for (int s = 0; s < 5; s++) begin
			plc.seg_get(`DRC_SEG_IDX_MODEL, s[2:0]);
			wait_hi(seg_valid);
			chk("seg_data", seg_data, nm[159-32*s -: 32]);
		end
		plc.seg_get(8'h03, 3'h0);
		#1;
		chk("seg_err", seg_err, 1);
		plc.seg_get(`DRC_SEG_IDX_MODEL, 3'h5);
		#1;
		chk("seg_err", seg_err, 1);
		$display("done segment");
		report_and_stop();
	end
	// whole run is about 110 cycles
	initial begin
		#20000;
		err_count++;
		report_and_stop();
	end
endmodule : drive_run_command_params_test
bind drc_core drc_core_monitor mon (.clk(clk), .rst(rst), .pd_valid(pd_valid), .pd_ctrl(pd_ctrl),
	.pd_target(pd_target), .rec_valid(rec_valid), .rec_byte(rec_byte), .rec_last(rec_last), .seg_req(seg_req),
	.seg_valid(seg_valid), .ctrl_word(ctrl_word), .goal_pos(goal_pos), .motion(motion), .direct_run(direct_run));
`default_nettype wire
